// ==== rtl/miu_interrupt_unit.sv ====
// Interrupt unit: flags, enables, AXI4-Lite registers and entry/return sequencer
//
// Functional notes
// RULE_01: Sources: external pin, two timers, keyboard.
// RULE_02: Entry pushes next instruction address.
// RULE_03: Entry clears global enable.
// RULE_04: Entry waits for instruction completion.
// RULE_05: Entry loads program counter with vector.
// RULE_06: Return sets global enable, pops counter.
// RULE_07: Selected pin edge sets external flag.
// RULE_08: External request needs global and own enable.
// RULE_09: External input use masks pin keyboard function.
// RULE_10: Timer overflow sets its own flag.
// RULE_11: Timer request needs global and own enable.
// RULE_12: Six keyboard pins, each own enable.
// RULE_13: Enabled pin level change sets keyboard flag.
// RULE_14: Keyboard request needs global and own enable.
// RULE_15: Pin enables map bits 5:0, reset 0.
// RULE_16: Misc bit 6 enables external input.
// RULE_17: Firmware sets interrupt pins as inputs.
// RULE_18: Global enable zero masks all interrupts.
// RULE_19: Flags stay set until software clears.
// RULE_20: Flags set while disabled, serviced later.
// RULE_21: Pins synchronised before change detection.
//
// Implementation choices: the register offsets and the AXI4-Lite slave port.
module miu_interrupt_unit (
  input wire logic clk,
  input wire logic srst,
  input wire logic awvalid,
  output logic awready,
  input wire logic [miu_pkg::ADDR_W-1:0] awaddr,
  input wire logic wvalid,
  output logic wready,
  input wire logic [miu_pkg::DATA_W-1:0] wdata,
  input wire logic [3:0] wstrb,
  output logic bvalid,
  input wire logic bready,
  output logic [1:0] bresp,
  input wire logic arvalid,
  output logic arready,
  input wire logic [miu_pkg::ADDR_W-1:0] araddr,
  output logic rvalid,
  input wire logic rready,
  output logic [miu_pkg::DATA_W-1:0] rdata,
  output logic [1:0] rresp,
  input wire logic [miu_pkg::KBD_PINS-1:0] portPins,
  input wire logic [1:0] timerOverflow,
  input wire logic instrDone,
  input wire logic [miu_pkg::PC_W-1:0] nextPc,
  input wire logic retFromIrq,
  input wire logic [miu_pkg::PC_W-1:0] stackTopData,
  output logic irqTake,
  output logic stackPush,
  output logic [miu_pkg::PC_W-1:0] stackPushData,
  output logic stackPop,
  output logic pcLoad,
  output logic [miu_pkg::PC_W-1:0] pcLoadValue,
  output logic seqBusy
);
  import miu_pkg::*;

  // Register state
  logic [7:0] miscControl_reg; // Watchdog bit, external input enable, stored bits
  logic [KBD_PINS-1:0] keyboardPinEnable_reg; // Per-pin keyboard enables
  logic globalIrqEnable_reg; // Global enable
  logic [SRC_W-1:0] srcEnable_reg; // Per-source enables
  logic [SRC_W-1:0] irqFlag_reg; // Sticky source flags
  logic extPinEdgeSelect_reg; // 1 rising, 0 falling

  // Bus write side
  logic awHeld_reg; // Write address captured
  logic wHeld_reg; // Write data captured
  logic [ADDR_W-1:0] awAddr_reg;
  logic [7:0] wByte_reg; // Only byte lane 0 carries register bits
  logic wLane_reg; // Lane 0 strobe
  logic bvalid_reg;
  logic [1:0] bresp_reg;
  logic wrFire; // Commit of a complete write

  // Bus read side
  logic rvalid_reg;
  logic [DATA_W-1:0] rdata_reg;
  logic [1:0] rresp_reg;

  // Pin events
  logic [KBD_PINS-1:0] pinRise;
  logic [KBD_PINS-1:0] pinFall;
  logic extInEn; // Shared pin serves the external interrupt
  logic [KBD_PINS-1:0] kbdEffEnable; // Enables after shared-pin masking
  logic extEvent;
  logic kbdEvent;
  logic [SRC_W-1:0] flagSet;
  logic [SRC_W-1:0] flagClear;
  logic irqPending;

  // Sequencer
  miu_seq_e seqState_reg;
  miu_seq_e seqState_next;
  logic retAccept;

  // Pin synchroniser for all six port pins, external input included
  miu_pin_sync #(
    .W(KBD_PINS)
  ) u_pin_sync (
    .clk(clk),
    .srst(srst),
    .pinIn(portPins), // RULE_21
    .pinRise(pinRise),
    .pinFall(pinFall)
  );

  // Write channels accepted independently, refused while a response waits
  assign awready = !awHeld_reg && !bvalid_reg;
  assign wready = !wHeld_reg && !bvalid_reg;
  assign wrFire = awHeld_reg && wHeld_reg && !bvalid_reg;
  assign bvalid = bvalid_reg;
  assign bresp = bresp_reg;

  // Capture of write address and data
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      awHeld_reg <= 1'b0;
      wHeld_reg <= 1'b0;
      awAddr_reg <= '0;
      wByte_reg <= '0;
      wLane_reg <= 1'b0;
    end
    else
    begin
      if (awvalid && awready)
      begin
        awHeld_reg <= 1'b1;
        awAddr_reg <= awaddr;
      end
      else if (wrFire)
        awHeld_reg <= 1'b0;
      if (wvalid && wready)
      begin
        wHeld_reg <= 1'b1;
        wByte_reg <= wdata[7:0];
        wLane_reg <= wstrb[0];
      end
      else if (wrFire)
        wHeld_reg <= 1'b0;
    end
  end

  // Write response, error for an unmapped word
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      bvalid_reg <= 1'b0;
      bresp_reg <= RESP_OKAY;
    end
    else if (wrFire)
    begin
      bvalid_reg <= 1'b1;
      case (awAddr_reg)
        OFF_MISC_CTRL, OFF_KBD_PIN_EN, OFF_IRQ_EN, OFF_IRQ_FLAG, OFF_EDGE_CTRL:
          bresp_reg <= RESP_OKAY;
        default:
          bresp_reg <= RESP_SLVERR;
      endcase
    end
    else if (bvalid_reg && bready)
      bvalid_reg <= 1'b0;
  end

  // Plain configuration registers
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      miscControl_reg <= MISC_CTRL_RST; // RULE_16
      keyboardPinEnable_reg <= KBD_PIN_EN_RST; // RULE_15
      srcEnable_reg <= SRC_EN_RST;
      extPinEdgeSelect_reg <= EDGE_SEL_RST;
    end
    else if (wrFire && wLane_reg)
    begin
      case (awAddr_reg)
        OFF_MISC_CTRL:
        begin
          // Detector status bit is read-only and stays zero here
          miscControl_reg <= wByte_reg & ~(8'h01 << MISC_RO_BIT);
        end
        OFF_KBD_PIN_EN:
          keyboardPinEnable_reg <= wByte_reg[KBD_PINS-1:0]; // RULE_12
        OFF_IRQ_EN:
          srcEnable_reg <= wByte_reg[SRC_W-1:0];
        OFF_EDGE_CTRL:
          extPinEdgeSelect_reg <= wByte_reg[EDGE_SEL_BIT];
        default:
        begin
          // Flags and unmapped words handled elsewhere
        end
      endcase
    end
  end

  // Global enable: hardware clear on entry beats a software write
  always_ff @(posedge clk)
  begin
    if (srst)
      globalIrqEnable_reg <= GLOBAL_EN_RST;
    else if (irqTake)
      globalIrqEnable_reg <= 1'b0; // RULE_03
    else if (retAccept)
      globalIrqEnable_reg <= 1'b1; // RULE_06
    else if (wrFire && wLane_reg && awAddr_reg == OFF_IRQ_EN)
      globalIrqEnable_reg <= wByte_reg[IRQ_GLOBAL_EN_BIT];
  end

  // Source events
  assign extInEn = miscControl_reg[MISC_EXT_IN_EN_BIT]; // RULE_16
  assign extEvent = extInEn && (extPinEdgeSelect_reg ? pinRise[SHARED_PIN]
                                                     : pinFall[SHARED_PIN]); // RULE_07
  // Shared pin loses its keyboard role while it is the external input
  always_comb
  begin
    kbdEffEnable = keyboardPinEnable_reg; // RULE_15
    if (extInEn)
      kbdEffEnable[SHARED_PIN] = 1'b0; // RULE_09
  end
  assign kbdEvent = |((pinRise | pinFall) & kbdEffEnable); // RULE_13

  // Flag set and clear masks; events ignore global and source enables
  always_comb
  begin
    flagSet = '0;
    flagSet[SRC_EXT_BIT] = extEvent; // RULE_20
    flagSet[SRC_KBD_BIT] = kbdEvent; // RULE_01
    flagSet[SRC_TIMER_ZERO_BIT] = timerOverflow[0]; // RULE_10
    flagSet[SRC_TIMER_ONE_BIT] = timerOverflow[1];
    // Software clears a flag by writing 0 to it; a 1 leaves it alone
    flagClear = '0;
    if (wrFire && wLane_reg && awAddr_reg == OFF_IRQ_FLAG)
      flagClear = ~wByte_reg[SRC_W-1:0];
  end

  // Sticky flags, a same-cycle event wins over the clear
  always_ff @(posedge clk)
  begin
    if (srst)
      irqFlag_reg <= FLAG_RST;
    else
      irqFlag_reg <= (irqFlag_reg & ~flagClear) | flagSet; // RULE_19
  end

  // Request reaches the core only under both enables
  assign irqPending = globalIrqEnable_reg // RULE_08 RULE_11 RULE_14
                      && |(irqFlag_reg & srcEnable_reg); // RULE_18

  // Read channel, one read at a time
  assign arready = !rvalid_reg;
  assign rvalid = rvalid_reg;
  assign rdata = rdata_reg;
  assign rresp = rresp_reg;

  // Read decode, unmapped words return zero with an error
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      rvalid_reg <= 1'b0;
      rdata_reg <= '0;
      rresp_reg <= RESP_OKAY;
    end
    else if (arvalid && arready)
    begin
      rvalid_reg <= 1'b1;
      rdata_reg <= '0;
      rresp_reg <= RESP_OKAY;
      case (araddr)
        OFF_MISC_CTRL:
          rdata_reg[7:0] <= miscControl_reg;
        OFF_KBD_PIN_EN:
          rdata_reg[KBD_PINS-1:0] <= keyboardPinEnable_reg;
        OFF_IRQ_EN:
        begin
          rdata_reg[IRQ_GLOBAL_EN_BIT] <= globalIrqEnable_reg;
          rdata_reg[SRC_W-1:0] <= srcEnable_reg;
        end
        OFF_IRQ_FLAG:
          rdata_reg[SRC_W-1:0] <= irqFlag_reg;
        OFF_EDGE_CTRL:
          rdata_reg[EDGE_SEL_BIT] <= extPinEdgeSelect_reg;
        default:
          rresp_reg <= RESP_SLVERR;
      endcase
    end
    else if (rvalid_reg && rready)
      rvalid_reg <= 1'b0;
  end

  // Entry only at an instruction boundary; a return in that cycle goes first
  assign irqTake = (seqState_reg == SEQ_IDLE) && instrDone && irqPending
                   && !retFromIrq; // RULE_04
  assign retAccept = (seqState_reg == SEQ_IDLE) && retFromIrq;

  // Sequencer next state
  always_comb
  begin
    case (seqState_reg)
      SEQ_IDLE:
      begin
        if (retAccept)
          seqState_next = SEQ_POP;
        else if (irqTake)
          seqState_next = SEQ_PUSH;
        else
          seqState_next = SEQ_IDLE;
      end
      SEQ_PUSH:
        seqState_next = SEQ_VECTOR;
      SEQ_VECTOR:
        seqState_next = SEQ_IDLE;
      SEQ_POP:
        seqState_next = SEQ_RESUME;
      SEQ_RESUME:
        seqState_next = SEQ_IDLE;
      default:
        seqState_next = SEQ_IDLE;
    endcase
  end

  // Sequencer state register
  always_ff @(posedge clk)
  begin
    if (srst)
      seqState_reg <= SEQ_IDLE;
    else
      seqState_reg <= seqState_next;
  end

  // Return address captured at the boundary
  always_ff @(posedge clk)
  begin
    if (srst)
      stackPushData <= '0;
    else if (irqTake)
      stackPushData <= nextPc; // RULE_02
  end

  // Counter value: vector on entry, popped address on return
  always_ff @(posedge clk)
  begin
    if (srst)
      pcLoadValue <= '0;
    else if (seqState_reg == SEQ_PUSH)
      pcLoadValue <= IRQ_VECTOR; // RULE_05
    else if (seqState_reg == SEQ_POP)
      pcLoadValue <= stackTopData; // RULE_06
  end

  // Strobes to the core; the core stalls while busy
  assign stackPush = (seqState_reg == SEQ_PUSH);
  assign stackPop = (seqState_reg == SEQ_POP);
  assign pcLoad = (seqState_reg == SEQ_VECTOR) || (seqState_reg == SEQ_RESUME);
  assign seqBusy = (seqState_reg != SEQ_IDLE);

  // Checks
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (srst);

  property p_entry_push;
    irqTake |=> stackPush && stackPushData == $past(nextPc);
  endproperty
  a_entry_push: assert property (p_entry_push) else $error("push address wrong"); // RULE_02

  property p_entry_global;
    irqTake |=> !globalIrqEnable_reg ##1 !globalIrqEnable_reg;
  endproperty
  a_entry_global: assert property (p_entry_global) else $error("global enable kept"); // RULE_03

  property p_boundary;
    irqTake |-> instrDone && !seqBusy;
  endproperty
  a_boundary: assert property (p_boundary) else $error("entry off boundary"); // RULE_04

  property p_vector;
    irqTake |=> ##1 pcLoad && pcLoadValue == IRQ_VECTOR ##1 !seqBusy;
  endproperty
  a_vector: assert property (p_vector) else $error("vector load wrong"); // RULE_05

  property p_return;
    retAccept |=> globalIrqEnable_reg && stackPop ##1 pcLoad
                  && pcLoadValue == $past(stackTopData);
  endproperty
  a_return: assert property (p_return) else $error("return sequence wrong"); // RULE_06

  property p_ext_flag;
    extEvent |=> irqFlag_reg[SRC_EXT_BIT];
  endproperty
  a_ext_flag: assert property (p_ext_flag) else $error("external flag not set"); // RULE_07

  property p_shared_mask;
    extInEn && pinRise[SHARED_PIN] && !(|(pinRise[KBD_PINS-1:1] | pinFall[KBD_PINS-1:1]))
      |-> !kbdEvent;
  endproperty
  a_shared_mask: assert property (p_shared_mask) else $error("shared pin kept"); // RULE_09

  property p_timer_flag;
    timerOverflow[1] |=> irqFlag_reg[SRC_TIMER_ONE_BIT];
  endproperty
  a_timer_flag: assert property (p_timer_flag) else $error("timer flag not set"); // RULE_10

  property p_masked;
    !globalIrqEnable_reg || !(|(irqFlag_reg & srcEnable_reg)) |-> !irqTake;
  endproperty
  a_masked: assert property (p_masked) else $error("masked request taken"); // RULE_18

  property p_sticky;
    irqFlag_reg[SRC_KBD_BIT] && !flagClear[SRC_KBD_BIT] |=> irqFlag_reg[SRC_KBD_BIT];
  endproperty
  a_sticky: assert property (p_sticky) else $error("flag dropped"); // RULE_19

  c_entry: cover property (irqTake ##1 stackPush ##1 pcLoad);
  c_return: cover property (retAccept ##1 stackPop ##1 pcLoad);
  c_kbd: cover property (kbdEvent ##1 irqFlag_reg[SRC_KBD_BIT]);
  c_ext: cover property (extEvent && extPinEdgeSelect_reg);

endmodule : miu_interrupt_unit

// ==== rtl/miu_pkg.sv ====
// Shared constants, register map and state encoding of the interrupt unit
package miu_pkg;

  // Bus and core widths
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam int PC_W = 13;
  localparam int KBD_PINS = 6;
  localparam int SRC_W = 4;

  // Register byte offsets
  localparam logic [ADDR_W-1:0] OFF_MISC_CTRL = 8'h00;
  localparam logic [ADDR_W-1:0] OFF_KBD_PIN_EN = 8'h04;
  localparam logic [ADDR_W-1:0] OFF_IRQ_EN = 8'h08;
  localparam logic [ADDR_W-1:0] OFF_IRQ_FLAG = 8'h0C;
  localparam logic [ADDR_W-1:0] OFF_EDGE_CTRL = 8'h10;

  // Values after reset
  localparam logic [7:0] MISC_CTRL_RST = 8'h80;
  localparam logic [KBD_PINS-1:0] KBD_PIN_EN_RST = 6'h00;
  localparam logic [SRC_W-1:0] SRC_EN_RST = 4'h0;
  localparam logic [SRC_W-1:0] FLAG_RST = 4'h0;
  localparam logic GLOBAL_EN_RST = 1'b0;
  localparam logic EDGE_SEL_RST = 1'b0;

  // Field positions
  localparam int MISC_EXT_IN_EN_BIT = 6;
  localparam int MISC_RO_BIT = 5;
  localparam int IRQ_GLOBAL_EN_BIT = 7;
  localparam int SRC_TIMER_ONE_BIT = 3;
  localparam int SRC_EXT_BIT = 2;
  localparam int SRC_KBD_BIT = 1;
  localparam int SRC_TIMER_ZERO_BIT = 0;
  localparam int EDGE_SEL_BIT = 0;
  localparam int SHARED_PIN = 0;

  // Single service entry point
  localparam logic [PC_W-1:0] IRQ_VECTOR = 13'h0008;

  // Bus responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // Synchroniser warm-up length in cycles
  localparam int SYNC_PRIME = 3;

  // Entry and return sequencer states
  typedef enum logic [4:0] {
    SEQ_IDLE = 5'h01,
    SEQ_PUSH = 5'h02,
    SEQ_VECTOR = 5'h04,
    SEQ_POP = 5'h08,
    SEQ_RESUME = 5'h10
  } miu_seq_e;

endpackage : miu_pkg

// ==== rtl/miu_pin_sync.sv ====
// Two-stage pin synchroniser with rise and fall detection
module miu_pin_sync #(
  parameter int W = 6
) (
  input wire logic clk,
  input wire logic srst,
  input wire logic [W-1:0] pinIn,
  output logic [W-1:0] pinRise,
  output logic [W-1:0] pinFall
);
  import miu_pkg::*;

  logic [W-1:0] meta_reg; // First stage, read only by stage two
  logic [W-1:0] sync_reg; // Settled level
  logic [W-1:0] prev_reg; // Level one cycle earlier
  logic [SYNC_PRIME-1:0] prime_reg; // Warm-up, hides the reset-to-pin jump

  // Synchroniser chain
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      meta_reg <= '0;
      sync_reg <= '0;
      prev_reg <= '0;
    end
    else
    begin
      meta_reg <= pinIn;
      sync_reg <= meta_reg;
      prev_reg <= sync_reg;
    end
  end

  // Warm-up shift, so a pin held high through reset is no false edge
  always_ff @(posedge clk)
  begin
    if (srst)
      prime_reg <= '0;
    else
      prime_reg <= {prime_reg[SYNC_PRIME-2:0], 1'b1};
  end

  // Edges only once the chain holds real samples
  assign pinRise = prime_reg[SYNC_PRIME-1] ? (sync_reg & ~prev_reg) : '0;
  assign pinFall = prime_reg[SYNC_PRIME-1] ? (~sync_reg & prev_reg) : '0;

endmodule : miu_pin_sync

// ==== dv/miu_core_model.sv ====
// Behavioural processor core: instruction pacing, return requests, return stack
module miu_core_model (
  input wire logic clk,
  input wire logic srst,
  input wire logic run,
  input wire logic retReq,
  input wire logic seqBusy,
  input wire logic stackPush,
  input wire logic [miu_pkg::PC_W-1:0] stackPushData,
  input wire logic stackPop,
  input wire logic pcLoad,
  input wire logic [miu_pkg::PC_W-1:0] pcLoadValue,
  output logic instrDone,
  output logic [miu_pkg::PC_W-1:0] nextPc,
  output logic retFromIrq,
  output logic [miu_pkg::PC_W-1:0] stackTopData
);
  timeunit 1ns;
  timeprecision 1ps;
  import miu_pkg::*;
  logic [PC_W-1:0] pcReg; // Current instruction address
  logic [PC_W-1:0] stk [8]; // Return stack
  logic [3:0] sp; // Stack depth
  logic [PC_W-1:0] junk; // Filler while stack empty
  logic pace; // Random pacing, slow or prompt
  // Core stalls while the sequencer is busy
  assign instrDone = run && pace && !seqBusy && !retReq;
  assign retFromIrq = retReq && !seqBusy;
  assign nextPc = pcReg + 13'h0001;
  // Empty stack shows a changing pattern, never a stale value
  assign stackTopData = (sp != 4'h0) ? stk[3'(sp - 4'h1)] : junk;
  // Pacing, program counter and stack
  always_ff @(posedge clk)
  begin
    pace <= $urandom_range(0, 3) != 0;
    if (srst)
    begin
      pcReg <= 13'h0100;
      sp <= 4'h0;
      junk <= 13'h1555;
    end
    else
    begin
      junk <= ~junk;
      if (pcLoad)
        pcReg <= pcLoadValue;
      else if (instrDone)
        pcReg <= nextPc;
      if (stackPush)
      begin
        stk[sp[2:0]] <= stackPushData;
        sp <= sp + 4'h1;
      end
      else if (stackPop)
        sp <= sp - 4'h1;
    end
  end
endmodule : miu_core_model

// ==== dv/tb.sv ====
// Self-checking bench of the interrupt unit with a core model on its far side
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  import miu_pkg::*;
  logic clk = 1'b0;
  logic srst = 1'b1;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic awready, wready, bvalid, arready, rvalid, irqTake, stackPush, stackPop, pcLoad, seqBusy;
  logic [ADDR_W-1:0] awaddr = 8'h00, araddr = 8'h00;
  logic [DATA_W-1:0] wdata = 32'h0, rdata;
  logic [1:0] bresp, rresp, timerOverflow = 2'h0;
  logic [KBD_PINS-1:0] portPins = 6'h00; // Pins only ever inputs
  logic run = 1'b0, retReq = 1'b0, instrDone, retFromIrq, retPend = 1'b0, retSeen = 1'b0;
  logic [PC_W-1:0] nextPc, stackTopData, stackPushData, pcLoadValue, savedPc;
  int nMismatch = 0, nCompared = 0, nTake = 0, cyc = 0;
  always #5 clk = ~clk;
  miu_interrupt_unit dut_u (.clk(clk), .srst(srst), .awvalid(awvalid), .awready(awready),
    .awaddr(awaddr), .wvalid(wvalid), .wready(wready), .wdata(wdata), .wstrb(4'hF),
    .bvalid(bvalid), .bready(bready), .bresp(bresp), .arvalid(arvalid), .arready(arready),
    .araddr(araddr), .rvalid(rvalid), .rready(rready), .rdata(rdata), .rresp(rresp),
    .portPins(portPins), .timerOverflow(timerOverflow), .instrDone(instrDone),
    .nextPc(nextPc), .retFromIrq(retFromIrq), .stackTopData(stackTopData), .irqTake(irqTake),
    .stackPush(stackPush), .stackPushData(stackPushData), .stackPop(stackPop),
    .pcLoad(pcLoad), .pcLoadValue(pcLoadValue), .seqBusy(seqBusy));
  miu_core_model core_u (.clk(clk), .srst(srst), .run(run), .retReq(retReq),
    .seqBusy(seqBusy), .stackPush(stackPush), .stackPushData(stackPushData),
    .stackPop(stackPop), .pcLoad(pcLoad), .pcLoadValue(pcLoadValue), .instrDone(instrDone),
    .nextPc(nextPc), .retFromIrq(retFromIrq), .stackTopData(stackTopData));
  // Verdict, then end of run
  task automatic finalReport();
    if (nMismatch == 0 && nCompared > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : finalReport
  // One counted comparison
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    nCompared++;
    if (got !== exp)
    begin
      nMismatch++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask : tick
  // Bus write; address and data offered together, each released when taken
  task automatic axw(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    logic aDone;
    logic wDone;
    aDone = 1'b0;
    wDone = 1'b0;
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!(aDone && wDone))
    begin
      @(posedge clk);
      if (awvalid && awready)
        aDone = 1'b1;
      if (wvalid && wready)
        wDone = 1'b1;
      awvalid <= !aDone;
      wvalid <= !wDone;
    end
    do
      @(posedge clk);
    while (!bvalid);
    bready <= 1'b0;
    chk("bresp", {30'h0, er}, {30'h0, bresp});
    @(posedge clk);
  endtask : axw
  // Bus read compared against an expected word and response
  task automatic axr(input logic [7:0] a, input logic [31:0] exp, input logic [1:0] er,
    input string what);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do
      @(posedge clk);
    while (!arready);
    arvalid <= 1'b0;
    do
      @(posedge clk);
    while (!rvalid);
    rready <= 1'b0;
    chk(what, exp, rdata);
    chk("rresp", {30'h0, er}, {30'h0, rresp});
    @(posedge clk);
  endtask : axr
  // Event of one source: timer pulse or pin toggle
  task automatic raise(input int k);
    case (k)
      SRC_TIMER_ZERO_BIT: timerOverflow <= 2'b01;
      SRC_TIMER_ONE_BIT: timerOverflow <= 2'b10;
      SRC_KBD_BIT: portPins[1] <= !portPins[1];
      default: portPins[SHARED_PIN] <= !portPins[SHARED_PIN];
    endcase
    @(posedge clk);
    timerOverflow <= 2'b00;
    tick(8);
  endtask : raise
  // Core-side observer of entry and return, plus run timeout
  always @(posedge clk)
  begin
    if (!srst && irqTake)
    begin
      chk("take_at_boundary", 32'h1, {31'h0, instrDone});
      savedPc = nextPc;
      nTake++;
    end
    if (!srst && stackPush)
      chk("push_addr", {19'h0, savedPc}, {19'h0, stackPushData});
    if (!srst && pcLoad)
      chk("pc_load", {19'h0, retPend ? savedPc : IRQ_VECTOR}, {19'h0, pcLoadValue});
    if (pcLoad)
      retPend = 1'b0;
    if (stackPop)
      retPend = 1'b1;
    // Pop strobe must follow an accepted return by exactly one cycle
    if (!srst)
      chk("pop_after_ret", {31'h0, retSeen}, {31'h0, stackPop});
    retSeen = retFromIrq;
    // Timeout last, so nothing runs after the verdict
    cyc++;
    if (cyc > 40000)
    begin
      nMismatch++;
      finalReport();
    end
  end
  initial
  begin
    logic [31:0] r;
    int en;
    void'($urandom(32'h5C03E938));
    tick(4);
    srst <= 1'b0;
    run <= 1'b1;
    tick(4);
    axr(OFF_MISC_CTRL, 32'h80, RESP_OKAY, "misc_rst");
    axr(OFF_KBD_PIN_EN, 32'h0, RESP_OKAY, "kbd_en_rst");
    axr(OFF_IRQ_EN, 32'h0, RESP_OKAY, "irq_en_rst");
    axr(OFF_IRQ_FLAG, 32'h0, RESP_OKAY, "flag_rst");
    axr(8'h14, 32'h0, RESP_SLVERR, "unmapped_rd");
    axw(8'h14, 32'hFF, RESP_SLVERR);
    // Random register contents; flags are all clear so no entry
    repeat (4)
    begin
      r = $urandom();
      axw(OFF_MISC_CTRL, r, RESP_OKAY);
      axr(OFF_MISC_CTRL, {24'h0, r[7:0] & 8'hDF}, RESP_OKAY, "misc_rw");
      axw(OFF_KBD_PIN_EN, r, RESP_OKAY);
      axr(OFF_KBD_PIN_EN, {26'h0, r[5:0]}, RESP_OKAY, "kbd_en_rw");
      axw(OFF_IRQ_EN, r, RESP_OKAY);
      axr(OFF_IRQ_EN, {24'h0, r[7:0] & 8'h8F}, RESP_OKAY, "irq_en_rw");
    end
    axw(OFF_IRQ_EN, 32'h0, RESP_OKAY);
    axw(OFF_MISC_CTRL, 32'h0, RESP_OKAY);
    raise(SRC_TIMER_ZERO_BIT);
    raise(SRC_TIMER_ONE_BIT);
    tick(20);
    axr(OFF_IRQ_FLAG, 32'h9, RESP_OKAY, "timer_flags");
    axw(OFF_IRQ_FLAG, 32'h1, RESP_OKAY);
    axr(OFF_IRQ_FLAG, 32'h1, RESP_OKAY, "flag_clear");
    axw(OFF_IRQ_FLAG, 32'h0, RESP_OKAY);
    // Each pin rises then falls; only enabled pins count
    en = $urandom_range(1, 63);
    axw(OFF_KBD_PIN_EN, en, RESP_OKAY);
    for (int i = 0; i < 12; i++)
    begin
      portPins[i % 6] <= !portPins[i % 6];
      tick(8);
      axr(OFF_IRQ_FLAG, {30'h0, en[i % 6], 1'b0}, RESP_OKAY, "kbd_flag");
      axw(OFF_IRQ_FLAG, 32'h0, RESP_OKAY);
    end
    // External input on, shared pin keyboard enable left on
    axw(OFF_KBD_PIN_EN, 32'h3F, RESP_OKAY);
    axw(OFF_MISC_CTRL, 32'h40, RESP_OKAY);
    for (int s = 0; s < 2; s++)
    begin
      axw(OFF_EDGE_CTRL, s, RESP_OKAY);
      portPins[0] <= !s[0];
      tick(8);
      axr(OFF_IRQ_FLAG, 32'h0, RESP_OKAY, "ext_quiet");
      portPins[0] <= s[0];
      tick(8);
      axr(OFF_IRQ_FLAG, 32'h4, RESP_OKAY, "ext_edge");
      axw(OFF_IRQ_FLAG, 32'h0, RESP_OKAY);
    end
    // Shared pin now high, so falling mode makes the next toggle trigger
    axw(OFF_EDGE_CTRL, 32'h0, RESP_OKAY);
    for (int k = 0; k < SRC_W; k++)
    begin
      en = nTake;
      axw(OFF_IRQ_EN, 32'h0F, RESP_OKAY);
      raise(k);
      tick(20);
      chk("global_mask", en, nTake);
      axw(OFF_IRQ_EN, 32'h8F ^ (1 << k), RESP_OKAY);
      tick(30);
      chk("own_mask", en, nTake);
      axw(OFF_IRQ_EN, 32'h80 | (1 << k), RESP_OKAY);
      for (int t = 0; t < 200 && nTake == en; t++)
        @(posedge clk);
      chk("late_take", en + 1, nTake);
      tick(4);
      axr(OFF_IRQ_EN, 1 << k, RESP_OKAY, "global_cleared");
      axw(OFF_IRQ_FLAG, 32'h0, RESP_OKAY);
      retReq <= 1'b1;
      @(posedge clk);
      retReq <= 1'b0;
      tick(4);
      axr(OFF_IRQ_EN, 32'h80 | (1 << k), RESP_OKAY, "global_restored");
    end
    tick(10);
    finalReport();
  end
endmodule : tb
